// >>> rtl/ptp_pkg.sv
// Constants and state types of the period timer with six waveform channels.
// Assumes one 100 MHz clock and a 32-bit APB slave port.
`default_nettype none

package ptp_pkg;
    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL   = 8'hA1;
    localparam logic [7:0] IDX_CNT_LO = 8'hA2;
    localparam logic [7:0] IDX_CNT_HI = 8'hA3;
    localparam logic [7:0] IDX_PER_LO = 8'hA4;
    localparam logic [7:0] IDX_PER_HI = 8'hA5;
    localparam logic [7:0] IDX_IE_MAIN = 8'hA8;
    localparam logic [7:0] IDX_IE_SEC  = 8'h9A;
    localparam logic [7:0] IDX_IRQ2   = 8'hBF;
    localparam logic [7:0] IDX_INV    = 8'hBC;
    localparam logic [7:0] IDX_HALF   = 8'hBD;
    localparam logic [7:0] IDX_SEL    = 8'hBE;
    localparam logic [5:0][7:0] IDX_DUTY_LO = {8'hB5, 8'hB3, 8'hB1, 8'hAD, 8'hAB, 8'hA6};
    localparam logic [5:0][7:0] IDX_DUTY_HI = {8'hB6, 8'hB4, 8'hB2, 8'hAE, 8'hAC, 8'hA7};

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         CTRL_EN_BIT   = 7;
    localparam int         CTRL_RATE_LSB = 4;
    localparam int         IE_MAIN_ALL_BIT = 7;
    localparam int         IE_SEC_PER_BIT  = 1;
    localparam int         IRQ2_FLAG_BIT = 1;
    localparam int         NUM_CH        = 6;
    localparam int         APB_AW        = 12;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [6:0]  PRE_FULL     = 7'h7F;

    typedef struct packed {
        logic [6:0] cnt;
    } ptp_pre_s;

    typedef struct packed {
        logic pin;
        logic owned;
        logic synced;
        logic phase;
    } ptp_chan_s;

    typedef struct packed {
        logic              en;
        logic [2:0]        rate;
        logic [5:0]        inv;
        logic [5:0]        half;
        logic [5:0]        sel;
        logic [15:0]       period;
        logic [15:0]       act_per;
        logic [15:0]       count;
        logic [5:0][15:0]  duty;
        logic              all_ie;
        logic              per_ie;
        logic              flag;
        logic              stopped;
        logic              ready;
        logic              slverr;
        logic [31:0]       rdata;
        logic              irq;
        logic              wake;
    } ptp_state_s;
endpackage

`default_nettype wire

// >>> rtl/ptp_prescaler.sv
// Clock divider that makes the counter tick from the system clock.
// Assumes the rate select and run level come from the same clock.
`default_nettype none

module ptp_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    output logic            tick
);
    import ptp_pkg::*;

    ptp_pre_s   r;
    ptp_pre_s   n;
    logic [6:0] mask;

    // Mask shrinks by one bit per rate step: 0 divides by 128, 7 by 1
    always_comb begin
        n    = r;
        mask = PRE_FULL >> rate;
        tick = run && ((r.cnt & mask) == mask); // R13
        n.cnt = run ? r.cnt + 7'h01 : 7'h00;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/ptp_channel.sv
// One waveform channel: compare, invert, half rate and pin handover.
// Assumes counter, duty and controls come from the same clock.
`default_nettype none

module ptp_channel (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic        start,
    input  wire logic        wrap,
    input  wire logic [15:0] count,
    input  wire logic [15:0] period,
    input  wire logic [15:0] duty,
    input  wire logic        select,
    input  wire logic        invert,
    input  wire logic        half,
    input  wire logic        gpio_level,
    output logic             pin_level,
    output logic             pin_owned
);
    import ptp_pkg::*;

    ptp_chan_s   r;
    ptp_chan_s   n;
    logic [16:0] span;
    logic        wave;

    // Half rate treats two periods as one span and doubles the duty
    always_comb begin
        n    = r;
        span = r.phase ? {1'b0, period} + {1'b0, count} : {1'b0, count};
        wave = half ? (span < {duty, 1'b0}) : (count < duty); // R2 R6 R8 R15
        // Handover waits for a cycle start, so no partial pulse appears unless half is set and phase is high
        if (!run || !select) begin
            n.synced = 1'b0; // R3 R4
        end else if (start) begin
            n.synced = 1'b1; // R5
        end
        if (!run) begin
            n.phase = 1'b0;
        end else if (wrap) begin
            n.phase = ~r.phase; // R15
        end
        n.owned = n.synced;
        n.pin   = n.synced ? (wave ^ invert) : gpio_level; // R3 R14
    end

    assign pin_level = r.pin;
    assign pin_owned = r.owned;

    // State register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/ptp_top.sv
// Period timer with six waveform channels behind an APB register slave.
// Assumes one 100 MHz clock; GPIO levels and the vector acknowledge
// come from logic on that same clock.
//
// Overview of operation
// R1 - 16-bit counter clears at period, raises interrupt
// R2 - Six channels, each with own duty
// R3 - Select bit hands pin; clearing restores GPIO
// R4 - Timer enable low returns pins to GPIO
// R5 - Pin handover only at a cycle start
// R6 - Output high when counter starts at zero
// R7 - Counter cycle length comes from period register
// R8 - Output goes low when counter equals duty
// R9 - Period minus one wraps to zero, outputs high
// R10 - Wrap sets period flag; software reads, writes
// R11 - Enabled flag requests interrupt and wakes idle
// R12 - Software keeps duty not above period
// R13 - Divider select: 128 down to undivided
// R14 - Invert bit complements the pin waveform
// R15 - Frequency bit halves the pin waveform rate
// R16 - Enabling with zero period stops timer
// R17 - Software sets period before enabling timer
// R18 - Request flag is bit 1 of request register
// R19 - Select bits 5 to 0 choose waveform
// R20 - Vector acknowledge clears the period flag
//
// The APB slave port was left to the implementer.
`default_nettype none

module ptp_top (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ptp_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [5:0]                gpio_level,
    input  wire logic                      int_ack,
    output logic [5:0]                     wave_out_n,
    output logic [5:0]                     pin_owned,
    output logic                           period_irq,
    output logic                           idle_wake
);
    import ptp_pkg::*;

    // ----------------------------------------------------------------
    // State and shared combinational terms
    // ----------------------------------------------------------------
    ptp_state_s r;
    ptp_state_s n;
    logic       tick;
    logic       running;
    logic       wrap;
    logic       start;
    logic       access;
    logic       do_wr;
    logic       hit;
    logic       addr_ok;
    logic [7:0] idx;
    logic [7:0] rd;
    logic [7:0] wb;

    assign running = r.en && !r.stopped;
    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == '0);
    assign access  = psel && penable;
    assign do_wr   = access && r.ready && pwrite && hit;
    assign wb      = pwdata[7:0];

    // Cycle boundaries seen by every channel
    assign wrap  = tick && running && (r.count == r.act_per - 16'h0001); // R9
    assign start = tick && running && (r.count == RST_WORD); // R6

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    // Unlisted bits of the shared enable and request registers read zero
    always_comb begin
        rd  = RST_BYTE;
        hit = 1'b1;
        case (idx)
            IDX_CTRL:   rd = {r.en, r.rate, 4'h0};
            IDX_CNT_LO: rd = r.count[7:0];
            IDX_CNT_HI: rd = r.count[15:8];
            IDX_PER_LO: rd = r.period[7:0];
            IDX_PER_HI: rd = r.period[15:8];
            IDX_IE_MAIN: rd = {r.all_ie, 7'h00};
            IDX_IE_SEC:  rd = {6'h00, r.per_ie, 1'b0};
            IDX_IRQ2:   rd = {6'h00, r.flag, 1'b0}; // R18
            IDX_INV:    rd = {2'b00, r.inv};
            IDX_HALF:   rd = {2'b00, r.half};
            IDX_SEL:    rd = {2'b00, r.sel};
            default:    hit = 1'b0;
        endcase
        for (int i = 0; i < NUM_CH; i++) begin
            if (idx == IDX_DUTY_LO[i]) begin
                rd  = r.duty[i][7:0];
                hit = 1'b1;
            end
            if (idx == IDX_DUTY_HI[i]) begin
                rd  = r.duty[i][15:8];
                hit = 1'b1;
            end
        end
        if (!addr_ok) begin
            hit = 1'b0;
            rd  = RST_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;

        // Bus answer: one wait state; ready, error and data stand one cycle
        // Data and error clear with ready so a stale byte never lingers
        n.ready  = 1'b0;
        n.slverr = 1'b0;
        n.rdata  = 32'h00000000;
        if (access && !r.ready) begin
            n.ready  = 1'b1;
            n.slverr = !hit;
            n.rdata  = {24'h000000, rd};
        end

        // Register writes take effect on the edge that completes the access
        if (do_wr) begin
            case (idx)
                IDX_CTRL: begin
                    n.rate = wb[CTRL_RATE_LSB +: 3]; // R13
                    n.en   = wb[CTRL_EN_BIT];
                    if (!wb[CTRL_EN_BIT]) begin
                        n.stopped = 1'b0; // R4
                    end else if (!r.en) begin
                        // A zero period at enable locks the timer until disabled
                        n.stopped = (r.period == RST_WORD); // R16
                        n.count   = RST_WORD;
                        n.act_per = r.period; // R7
                    end
                end
                IDX_PER_LO: begin
                    if (!r.stopped) begin
                        n.period[7:0] = wb; // R16
                    end
                end
                IDX_PER_HI: begin
                    if (!r.stopped) begin
                        n.period[15:8] = wb; // R16
                    end
                end
                IDX_IE_MAIN: n.all_ie = wb[IE_MAIN_ALL_BIT];
                IDX_IE_SEC:  n.per_ie = wb[IE_SEC_PER_BIT]; // R11
                IDX_IRQ2: n.flag   = wb[IRQ2_FLAG_BIT]; // R10 R18
                IDX_INV:  n.inv    = wb[5:0]; // R14
                IDX_HALF: n.half   = wb[5:0]; // R15
                IDX_SEL:  n.sel    = wb[5:0]; // R3 R19
                default: begin
                end
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                if (idx == IDX_DUTY_LO[i]) begin
                    n.duty[i][7:0] = wb; // R2
                end
                if (idx == IDX_DUTY_HI[i]) begin
                    n.duty[i][15:8] = wb; // R2
                end
            end
        end

        // Counter: counts on each divided tick, wraps at period minus one
        if (!r.en) begin
            n.count = RST_WORD;
        end else if (wrap) begin
            n.count   = RST_WORD; // R1 R9
            n.act_per = r.period; // R7
        end else if (tick && running) begin
            n.count = r.count + 16'h0001;
        end

        // Vector acknowledge clears the flag
        if (int_ack) begin
            n.flag = 1'b0; // R20
        end
        // Wrap comes last so a set in the same cycle as a clear wins
        if (wrap) begin
            n.flag = 1'b1; // R1 R10
        end

        // Requests follow the flag; wake needs only the period interrupt enable, not the main one
        n.irq  = n.flag && n.per_ie && n.all_ie; // R11
        n.wake = n.flag && n.per_ie; // R11
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Frozen while the clock enable is low, bus answer included
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign prdata     = r.rdata;
    assign pready     = r.ready;
    assign pslverr    = r.slverr;
    assign period_irq = r.irq;
    assign idle_wake  = r.wake;

    // ----------------------------------------------------------------
    // Divider and channels
    // ----------------------------------------------------------------
    ptp_prescaler u_pre (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .run     (running),
        .rate    (r.rate),
        .tick    (tick)
    );

    // Each channel registers its own pin level and ownership
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        ptp_channel u_ch (
            .sys_clk    (sys_clk),
            .rstn       (rstn),
            .ce         (ce),
            .run        (running),
            .start      (start),
            .wrap       (wrap),
            .count      (r.count),
            .period     (r.act_per),
            .duty       (r.duty[g]),
            .select     (r.sel[g]),
            .invert     (r.inv[g]),
            .half       (r.half[g]),
            .gpio_level (gpio_level[g]),
            .pin_level  (wave_out_n[g]),
            .pin_owned  (pin_owned[g])
        );
    end
endmodule

`default_nettype wire

// >>> sim/ptp_asserts.sv
// Port checker of the period timer, bound into ptp_top.
// Assumes one clock domain and a master keeping the APB order.
`default_nettype none
module ptp_asserts (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  gpio_level,
    input wire logic        int_ack,
    input wire logic [5:0]  wave_out_n,
    input wire logic [5:0]  pin_owned,
    input wire logic        period_irq,
    input wire logic        idle_wake
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------
    // Bus and pin rules
    // -----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // A request has two steps: setup, then access
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence
    answer_wait_a: assert property (s_setup ##1 s_access |=> pready)
        else $error("bus answer late");
    answer_pulse_a: assert property (pready && ce |=> !pready)
        else $error("answer held");
    bad_addr_a: assert property (s_setup ##1 s_access ##0 paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned not refused");
    idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("data outside answer");
    byte_data_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("data above byte");
    // A pin nobody owns copies the gpio level one edge later
    gpio_hold_a: assert property ($past(rstn) && $past(ce) |->
        ((wave_out_n ^ $past(gpio_level)) & ~pin_owned) == 6'h00)
        else $error("free pin not at gpio level");
    wake_gate_a: assert property (period_irq |-> idle_wake)
        else $error("interrupt without wake");
    // Wake only drops after an acknowledge or a bus write
    flag_clear_a: assert property ($fell(idle_wake) |->
        $past(int_ack) || $past(int_ack, 2) || $past(pready) || $past(pready, 2))
        else $error("wake dropped without cause");
    // A low clock enable freezes pins and bus answer alike
    freeze_hold_a: assert property (!ce |=> $stable(wave_out_n) && $stable(pin_owned) && $stable(prdata))
        else $error("state moved while frozen");
endmodule

bind ptp_top ptp_asserts chk_u (.sys_clk, .rstn, .ce, .psel, .penable, .paddr, .prdata,
    .pready, .pslverr, .gpio_level, .int_ack, .wave_out_n, .pin_owned, .period_irq,
    .idle_wake);
`default_nettype wire

// >>> sim/ptp_load.sv
// Load model on the six pins: counts high cycles and rising edges.
// Assumes the pins are sampled on the system clock.
`default_nettype none
module ptp_load (
    input  wire logic             sys_clk,
    input  wire logic             clr,
    input  wire logic [5:0]       wave_out_n,
    output logic      [5:0][15:0] hi_cnt,
    output logic      [5:0][15:0] rise_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] last_lvl = 6'h00;
    // -------------
    // Pin watching
    // -------------
    // Last level survives a clear, so an edge at the window start counts
    always @(posedge sys_clk) begin
        for (int c = 0; c < 6; c++) begin
            hi_cnt[c]   <= clr ? 16'h0 : hi_cnt[c] + 16'(wave_out_n[c]);
            rise_cnt[c] <= clr ? 16'h0 : rise_cnt[c] + 16'(wave_out_n[c] & ~last_lvl[c]);
        end
        last_lvl <= wave_out_n;
    end
endmodule
`default_nettype wire

// >>> sim/period_timer_six_channel_pwm_bench.sv
// Self-checking bench of the period timer with six waveform channels.
// Assumes ptp_top, ptp_load and the bound checker are compiled first.
`default_nettype none
module period_timer_six_channel_pwm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ptp_pkg::*;
    logic             sys_clk = 1'h0;
    logic             rstn = 1'h0;
    logic             ce = 1'h1;
    logic             psel = 1'h0;
    logic             penable = 1'h0;
    logic             pwrite = 1'h0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0;
    logic [5:0]       gpio_level = 6'h00;
    logic             int_ack = 1'h0;
    logic             clr = 1'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [5:0]       wave_out_n;
    logic [5:0]       pin_owned;
    logic             period_irq;
    logic             idle_wake;
    logic [5:0][15:0] hi_cnt;
    logic [5:0][15:0] rise_cnt;
    logic [31:0]      seed = 32'h29;
    int               error_cnt = 0;
    int               n_compared = 0;
    // ---------------------------
    // Clock, design and pin loads
    // ---------------------------
    always #5 sys_clk = ~sys_clk;
    ptp_top dut_u (.sys_clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .gpio_level, .int_ack, .wave_out_n, .pin_owned,
        .period_irq, .idle_wake);
    ptp_load load_u (.sys_clk, .clr, .wave_out_n, .hi_cnt, .rise_cnt);
    // Fixed-seed xorshift keeps every run the same
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // High cycles in the window; a free pin shows its gpio level
    function automatic logic [15:0] exp_hi(input logic [15:0] w, dc, pr,
                                           input logic iv, s, g);
        if (!s) return g ? w : 16'h0;
        return iv ? w - w / pr * dc : w / pr * dc;
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output logic er);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'h1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] idx, d);
        logic [7:0] r;
        logic e;
        apb(1'h1, {2'h0, idx, 2'h0}, d, r, e);
    endtask
    task automatic rdc(input logic [7:0] idx, exp);
        logic [7:0] r;
        logic e;
        apb(1'h0, {2'h0, idx, 2'h0}, 8'h00, r, e);
        chk({7'h0, e, r}, {8'h00, exp});
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog sized well above the longest divider round
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    // ---------
    // Scenarios
    // ---------
    initial begin
        logic [7:0] r;
        logic e;
        logic [15:0] p;
        logic [15:0] win;
        logic [5:0] inv;
        logic [5:0] half;
        logic [5:0] sel;
        logic [5:0][15:0] d;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'h1;
        rdc(IDX_CTRL, 8'h00);
        rdc(IDX_DUTY_HI[5], 8'h00);
        rdc(IDX_IRQ2, 8'h00);
        apb(1'h1, 12'h041, 8'h55, r, e);
        chk({15'h0, e}, 16'h1);
        $display("reset done");
        // Every divider with random period, duties and pin modes
        for (int rt = 0; rt < 8; rt++) begin
            p = 16'(2 + rnd() % 6);
            win = 16'(4 << (7 - rt)) * p;
            inv = 6'(rnd());
            half = 6'(rnd());
            sel = 6'(rnd());
            gpio_level <= 6'(rnd());
            wr(IDX_PER_LO, p[7:0]);
            wr(IDX_PER_HI, 8'h00);
            for (int c = 0; c < NUM_CH; c++) begin
                d[c] = 16'(1 + rnd() % (p - 1));
                wr(IDX_DUTY_LO[c], d[c][7:0]);
                wr(IDX_DUTY_HI[c], 8'h00);
            end
            wr(IDX_INV, {2'h0, inv});
            wr(IDX_HALF, {2'h0, half});
            wr(IDX_SEL, {2'h0, sel});
            rdc(IDX_PER_LO, p[7:0]);
            wr(IDX_CTRL, {1'h1, 3'(rt), 4'h0});
            repeat (win) @(posedge sys_clk);
            clr <= 1'h1;
            @(posedge sys_clk);
            clr <= 1'h0;
            repeat (win) @(posedge sys_clk);
            #1;
            for (int c = 0; c < NUM_CH; c++) begin
                chk(hi_cnt[c], exp_hi(win, d[c], p, inv[c], sel[c], gpio_level[c]));
                chk(rise_cnt[c], sel[c] ? (half[c] ? 16'h2 : 16'h4) : 16'h0);
            end
            // Clock enable low must hold the pins where they stand
            ce <= 1'h0;
            repeat (2) @(posedge sys_clk);
            sel = wave_out_n;
            repeat (6) @(posedge sys_clk);
            chk({10'h0, wave_out_n}, {10'h0, sel});
            ce <= 1'h1;
            apb(1'h0, {2'h0, IDX_CNT_LO, 2'h0}, 8'h00, r, e);
            chk({15'h0, r < p[7:0]}, 16'h1);
            wr(IDX_CTRL, 8'h00);
            repeat (2) @(posedge sys_clk);
            #1;
            chk({4'h0, pin_owned, wave_out_n}, {10'h0, gpio_level});
            $display("rate %0d done", rt);
        end
        // Flag raised by the wraps above, then acknowledged, masked, written
        wr(IDX_IE_SEC, 8'h02);
        wr(IDX_IE_MAIN, 8'h80);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({14'h0, period_irq, idle_wake}, 16'h3);
        rdc(IDX_IRQ2, 8'h02);
        @(posedge sys_clk);
        int_ack <= 1'h1;
        @(posedge sys_clk);
        int_ack <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({14'h0, period_irq, idle_wake}, 16'h0);
        wr(IDX_IE_MAIN, 8'h00);
        wr(IDX_IRQ2, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({14'h0, period_irq, idle_wake}, 16'h1);
        wr(IDX_IRQ2, 8'h00);
        rdc(IDX_IRQ2, 8'h00);
        $display("flag done");
        // Zero period at enable stops the timer and locks the period
        wr(IDX_PER_LO, 8'h00);
        wr(IDX_CTRL, 8'h80);
        wr(IDX_PER_LO, 8'h05);
        rdc(IDX_PER_LO, 8'h00);
        rdc(IDX_CNT_LO, 8'h00);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_PER_LO, 8'h05);
        rdc(IDX_PER_LO, 8'h05);
        $display("stop done");
        stop_test();
    end
endmodule
`default_nettype wire
